// File: hw/adcpm_regs.svh
// Register offsets, field positions, reset values and timing counts of the converter host controller.
`ifndef ADCPM_REGS_SVH
`define ADCPM_REGS_SVH

// ****************************************************************
// Register offsets
// ****************************************************************
`define ADCPM_OFF_CTRL      8'h00
`define ADCPM_OFF_MODE      8'h04
`define ADCPM_OFF_CMD       8'h08
`define ADCPM_OFF_SHADOW    8'h0c
`define ADCPM_OFF_STATUS    8'h10
`define ADCPM_OFF_RESULT    8'h14

// ****************************************************************
// Frame word fields
// ****************************************************************
`define ADCPM_BIT_WRITE     15
`define ADCPM_BIT_SEQ       14
`define ADCPM_BIT_ADDR_HI   12
`define ADCPM_BIT_ADDR_LO   10
`define ADCPM_BIT_PM_HI     9
`define ADCPM_BIT_PM_LO     8
`define ADCPM_BIT_SHADOW    7
`define ADCPM_BIT_RANGE     5
`define ADCPM_ONES_WORD     16'hffff

// ****************************************************************
// Command and status bits
// ****************************************************************
`define ADCPM_CMD_CONV      0
`define ADCPM_CMD_INIT      1
`define ADCPM_CMD_CFG       2
`define ADCPM_CMD_SHADOW    3
`define ADCPM_STB_BUSY      0
`define ADCPM_STB_INIT      1
`define ADCPM_STB_VALID     2
`define ADCPM_STB_REFUSED   3
`define ADCPM_STB_ARMED     4
`define ADCPM_STB_MODE_LO   5
`define ADCPM_STB_MODE_HI   6

// ****************************************************************
// Power modes and reset values
// ****************************************************************
`define ADCPM_PM_NORMAL     2'b11
`define ADCPM_PM_FULL       2'b10
`define ADCPM_PM_AUTO       2'b01
`define ADCPM_RST_CTRL      16'h0000
`define ADCPM_RST_MODE      2'b11
`define ADCPM_RST_SHADOW    16'h0000

// ****************************************************************
// Timing
// ****************************************************************
`define ADCPM_CLK_NS        40
`define ADCPM_QUIET_NS      50
`define ADCPM_POWERUP_NS    1000
`define ADCPM_WAKE_NS       1000
`define ADCPM_QUIET_CYC     ((`ADCPM_QUIET_NS + `ADCPM_CLK_NS - 1) / `ADCPM_CLK_NS)
`define ADCPM_POWERUP_CYC   ((`ADCPM_POWERUP_NS + `ADCPM_CLK_NS - 1) / `ADCPM_CLK_NS)
`define ADCPM_WAKE_CYC      ((`ADCPM_WAKE_NS + `ADCPM_CLK_NS - 1) / `ADCPM_CLK_NS)
`define ADCPM_SCLK_HALF     4
`define ADCPM_FRAME_BITS    16

`endif

// File: hw/adcpm_pkg.sv
// Types shared by the converter host controller modules.
package adcpm_pkg;
	typedef enum logic [1:0] {SH_IDLE = 2'b00, SH_RUN = 2'b01, SH_TAIL = 2'b10} adcpm_sh_t;
	typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_START = 2'b01, ST_FRAME = 2'b10, ST_GAP = 2'b11} adcpm_st_t;
	typedef enum logic [1:0] {JOB_INIT = 2'b00, JOB_CONV = 2'b01, JOB_CFG = 2'b10, JOB_SHADOW = 2'b11} adcpm_job_t;
	typedef enum logic [2:0] {
		K_ONES   = 3'b000,
		K_CFG    = 3'b001,
		K_DUMMY  = 3'b010,
		K_CONV   = 3'b011,
		K_SHADOW = 3'b100
	} adcpm_kind_t;
endpackage

// File: hw/adcpm_shifter.sv
// Serial frame engine: makes chip select and the serial clock, shifts a word out and the result in.
`timescale 1ns/1ps
`include "adcpm_regs.svh"

module adcpm_shifter (
	input  logic        pclk,
	input  logic        presetn,
	input  logic        start,
	input  logic [15:0] tx_word,
	input  logic        dout_pin,
	output logic        cs_n,
	output logic        sclk,
	output logic        din,
	output logic        done,
	output logic [15:0] rx_word
);
	import adcpm_pkg::*;

	localparam logic [2:0] HALF_M1   = 3'(`ADCPM_SCLK_HALF - 1);
	localparam logic [4:0] LAST_EDGE = 5'(`ADCPM_FRAME_BITS);

	adcpm_sh_t   state;
	logic [2:0]  half_cnt;
	logic [4:0]  edge_cnt;
	logic [15:0] shreg;
	logic        dout_meta;
	logic        dout_sync;
	logic        fall_now;

	assign fall_now = (state == SH_RUN) && (half_cnt == HALF_M1) && sclk;

	// ****************************************************************
	// Data output synchroniser
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dout_meta <= 1'b0;
			dout_sync <= 1'b0;
		end else begin
			dout_meta <= dout_pin;
			dout_sync <= dout_meta;
		end
	end

	// ****************************************************************
	// Frame sequence
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state    <= SH_IDLE;
			cs_n     <= 1'b1;
			sclk     <= 1'b1;
			din      <= 1'b0;
			done     <= 1'b0;
			half_cnt <= 3'h0;
			edge_cnt <= 5'h00;
			shreg    <= 16'h0000;
		end else begin
			done <= 1'b0;
			case (state)
				SH_IDLE: begin
					if (start) begin
						cs_n     <= 1'b0;
						sclk     <= 1'b1;
						din      <= tx_word[15];
						shreg    <= {tx_word[14:0], 1'b0};
						edge_cnt <= 5'h00;
						half_cnt <= 3'h0;
						state    <= SH_RUN;
					end
				end
				SH_RUN: begin
					if (half_cnt == HALF_M1) begin
						half_cnt <= 3'h0;
						if (sclk) begin
							sclk     <= 1'b0;
							edge_cnt <= edge_cnt + 5'h01;
						end else begin
							sclk <= 1'b1;
							// Sixteen clocks are always given before the frame closes.
							if (edge_cnt == LAST_EDGE) begin
								state <= SH_TAIL;
							end else begin
								din   <= shreg[15];
								shreg <= {shreg[14:0], 1'b0};
							end
						end
					end else begin
						half_cnt <= half_cnt + 3'h1;
					end
				end
				SH_TAIL: begin
					if (half_cnt == HALF_M1) begin
						half_cnt <= 3'h0;
						cs_n     <= 1'b1;
						din      <= 1'b0;
						done     <= 1'b1;
						state    <= SH_IDLE;
					end else begin
						half_cnt <= half_cnt + 3'h1;
					end
				end
				default: state <= SH_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Result capture on each falling serial clock edge
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_word <= 16'h0000;
		end else if (fall_now) begin
			rx_word <= {rx_word[14:0], dout_sync};
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	frame_len_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(cs_n) |-> edge_cnt == LAST_EDGE)
		else $error("frame closed without sixteen serial clocks");
	sclk_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
		cs_n |-> sclk)
		else $error("serial clock low outside a frame");
endmodule

// File: hw/adcpm_host.sv
// Host controller that initialises, configures and reads the eight-channel converter over its serial pins.
`timescale 1ns/1ps
`include "adcpm_regs.svh"

module adcpm_host (
	input  logic        pclk,
	input  logic        presetn,
	input  logic        psel,
	input  logic        penable,
	input  logic        pwrite,
	input  logic [7:0]  paddr,
	input  logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic        pready,
	output logic        pslverr,
	output logic        adc_cs_n,
	output logic        adc_sclk,
	output logic        adc_din,
	input  logic        adc_dout
);
	import adcpm_pkg::*;

	localparam logic [7:0] QUIET_CYC   = 8'(`ADCPM_QUIET_CYC);
	localparam logic [7:0] POWERUP_CYC = 8'(`ADCPM_POWERUP_CYC);
	localparam logic [7:0] WAKE_CYC    = 8'(`ADCPM_WAKE_CYC);

	// ****************************************************************
	// Declarations
	// ****************************************************************
	logic [15:0] ctrl_word;
	logic [1:0]  mode_reg;
	logic [15:0] shadow_data;
	logic [15:0] result;
	logic        init_done;
	logic [1:0]  dev_mode;
	logic        shadow_armed;
	logic        result_valid;
	logic        refused;

	adcpm_st_t   state;
	adcpm_job_t  job;
	logic [1:0]  step;
	logic        cur_auto;
	logic        skip2;
	logic        last_flag;
	adcpm_kind_t cur_kind;
	adcpm_kind_t prev_kind;
	adcpm_kind_t next_kind;
	logic        sh_start;
	logic [15:0] sh_tx;
	logic [15:0] next_tx;
	logic        sh_done;
	logic [15:0] sh_rx;
	logic [7:0]  gap_cnt;
	logic [7:0]  wake_cnt;
	logic [7:0]  hi_cnt;
	logic        pwr_armed;

	logic        wr_en;
	logic        cmd_wr;
	logic        cmd_any;
	logic        cmd_ok;
	adcpm_job_t  cmd_job;
	logic        frame_last;
	logic        need_pwr;
	logic        go_ok;
	logic [31:0] rd_val;

	// ****************************************************************
	// Functions
	// ****************************************************************
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `ADCPM_OFF_CTRL) || (a == `ADCPM_OFF_MODE) || (a == `ADCPM_OFF_CMD) ||
			(a == `ADCPM_OFF_SHADOW) || (a == `ADCPM_OFF_STATUS) || (a == `ADCPM_OFF_RESULT);
	endfunction

	function automatic adcpm_kind_t frame_kind(input adcpm_job_t j, input logic [1:0] s, input logic skp,
		input logic aut);
		case (j)
			JOB_INIT: begin
				if (s == 2'h0) begin
					frame_kind = K_ONES;
				end else if (s == 2'h1) begin
					frame_kind = skp ? K_CFG : K_ONES;
				end else begin
					frame_kind = K_CFG;
				end
			end
			JOB_CONV:   frame_kind = (aut && (s == 2'h0)) ? K_DUMMY : K_CONV;
			JOB_CFG:    frame_kind = K_CFG;
			JOB_SHADOW: frame_kind = K_SHADOW;
			default:    frame_kind = K_CONV;
		endcase
	endfunction

	// ****************************************************************
	// Register bus
	// ****************************************************************
	assign wr_en   = psel && penable && pready && pwrite;
	assign cmd_wr  = wr_en && (paddr == `ADCPM_OFF_CMD);
	assign cmd_any = |pwdata[`ADCPM_CMD_SHADOW:`ADCPM_CMD_CONV];

	always_comb begin
		rd_val = 32'h0000_0000;
		case (paddr)
			`ADCPM_OFF_CTRL:   rd_val = {16'h0000, ctrl_word};
			`ADCPM_OFF_MODE:   rd_val = {30'h0000_0000, mode_reg};
			`ADCPM_OFF_SHADOW: rd_val = {16'h0000, shadow_data};
			`ADCPM_OFF_STATUS: rd_val = {25'h000_0000, dev_mode, shadow_armed, refused, result_valid, init_done,
				state != ST_IDLE};
			`ADCPM_OFF_RESULT: rd_val = {16'h0000, result};
			default:           rd_val = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable && !pready;
			pslverr <= psel && !penable && !pready && !is_mapped(paddr);
			if (psel && !penable && !pwrite) begin
				prdata <= rd_val;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_word   <= `ADCPM_RST_CTRL;
			mode_reg    <= `ADCPM_RST_MODE;
			shadow_data <= `ADCPM_RST_SHADOW;
		end else if (wr_en) begin
			if (paddr == `ADCPM_OFF_CTRL) begin
				ctrl_word <= pwdata[15:0];
			end
			if ((paddr == `ADCPM_OFF_MODE) && (pwdata[1:0] != 2'b00)) begin
				mode_reg <= pwdata[1:0];
			end
			if (paddr == `ADCPM_OFF_SHADOW) begin
				shadow_data <= pwdata[15:0];
			end
		end
	end

	// ****************************************************************
	// Command decode
	// ****************************************************************
	always_comb begin
		cmd_job = JOB_CONV;
		cmd_ok  = 1'b0;
		if (pwdata[`ADCPM_CMD_INIT]) begin
			cmd_job = JOB_INIT;
			cmd_ok  = 1'b1;
		end else if (pwdata[`ADCPM_CMD_CFG]) begin
			cmd_job = JOB_CFG;
			cmd_ok  = init_done;
		end else if (pwdata[`ADCPM_CMD_SHADOW]) begin
			cmd_job = JOB_SHADOW;
			cmd_ok  = init_done && shadow_armed;
		end else if (pwdata[`ADCPM_CMD_CONV]) begin
			cmd_job = JOB_CONV;
			cmd_ok  = init_done;
		end
	end

	// ****************************************************************
	// Frame word build
	// ****************************************************************
	always_comb begin
		next_kind = frame_kind(job, step, skip2, cur_auto);
		case (next_kind)
			K_ONES:   next_tx = `ADCPM_ONES_WORD;
			K_CFG:    next_tx = {1'b1, ctrl_word[`ADCPM_BIT_SEQ:`ADCPM_BIT_ADDR_LO], mode_reg,
				ctrl_word[`ADCPM_BIT_SHADOW:0]};
			K_SHADOW: next_tx = shadow_data;
			default:  next_tx = {1'b0, ctrl_word[`ADCPM_BIT_SEQ:`ADCPM_BIT_ADDR_LO], mode_reg,
				ctrl_word[`ADCPM_BIT_SHADOW:0]};
		endcase
	end

	assign go_ok      = (next_kind != K_CONV) || !cur_auto || (wake_cnt == 8'h00);
	assign frame_last = (job == JOB_INIT) ? (cur_kind == K_CFG) : ((job == JOB_CONV) ? (cur_kind == K_CONV) : 1'b1);
	assign need_pwr   = (cur_kind == K_CFG) && (sh_tx[`ADCPM_BIT_PM_HI:`ADCPM_BIT_PM_LO] == `ADCPM_PM_NORMAL) &&
		(!init_done || (dev_mode == `ADCPM_PM_FULL));

	// ****************************************************************
	// Frame sequencer
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state     <= ST_IDLE;
			job       <= JOB_CONV;
			step      <= 2'h0;
			cur_auto  <= 1'b0;
			skip2     <= 1'b0;
			last_flag <= 1'b0;
			cur_kind  <= K_CONV;
			prev_kind <= K_CONV;
			sh_start  <= 1'b0;
			sh_tx     <= 16'h0000;
			gap_cnt   <= 8'h00;
		end else begin
			sh_start <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (cmd_wr && cmd_any && cmd_ok) begin
						job      <= cmd_job;
						step     <= 2'h0;
						cur_auto <= init_done && (dev_mode == `ADCPM_PM_AUTO);
						skip2    <= mode_reg != `ADCPM_PM_AUTO;
						state    <= ST_START;
					end
				end
				ST_START: begin
					if (go_ok) begin
						sh_start  <= 1'b1;
						sh_tx     <= next_tx;
						prev_kind <= cur_kind;
						cur_kind  <= next_kind;
						state     <= ST_FRAME;
					end
				end
				ST_FRAME: begin
					if (sh_done) begin
						last_flag <= frame_last;
						step      <= step + 2'h1;
						gap_cnt   <= need_pwr ? POWERUP_CYC : QUIET_CYC;
						state     <= ST_GAP;
					end
				end
				ST_GAP: begin
					// Chip select idles high here until the next frame is due.
					if (gap_cnt == 8'h00) begin
						state <= last_flag ? ST_IDLE : ST_START;
					end else begin
						gap_cnt <= gap_cnt - 8'h01;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// ****************************************************************
	// Wake timer for auto shutdown
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wake_cnt <= 8'h00;
		end else if ((state == ST_START) && go_ok && (next_kind == K_DUMMY)) begin
			wake_cnt <= WAKE_CYC;
		end else if (wake_cnt != 8'h00) begin
			wake_cnt <= wake_cnt - 8'h01;
		end
	end

	// ****************************************************************
	// Status and device state tracking
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_done    <= 1'b0;
			dev_mode     <= `ADCPM_PM_NORMAL;
			shadow_armed <= 1'b0;
			result_valid <= 1'b0;
			refused      <= 1'b0;
			result       <= 16'h0000;
		end else begin
			if ((state == ST_IDLE) && cmd_wr && cmd_any && cmd_ok && (cmd_job == JOB_INIT)) begin
				init_done <= 1'b0;
			end
			if ((state == ST_FRAME) && sh_done) begin
				if (cur_kind == K_CFG) begin
					dev_mode     <= sh_tx[`ADCPM_BIT_PM_HI:`ADCPM_BIT_PM_LO];
					shadow_armed <= !sh_tx[`ADCPM_BIT_SEQ] && sh_tx[`ADCPM_BIT_SHADOW];
					if (job == JOB_INIT) begin
						init_done <= 1'b1;
					end
				end
				if (cur_kind == K_SHADOW) begin
					shadow_armed <= 1'b0;
				end
				if (cur_kind == K_CONV) begin
					result <= sh_rx;
				end
			end
			if ((state == ST_FRAME) && sh_done && (cur_kind == K_CONV)) begin
				result_valid <= 1'b1;
			end else if (wr_en && (paddr == `ADCPM_OFF_STATUS) && pwdata[`ADCPM_STB_VALID]) begin
				result_valid <= 1'b0;
			end
			if (cmd_wr && cmd_any && !((state == ST_IDLE) && cmd_ok)) begin
				refused <= 1'b1;
			end else if (wr_en && (paddr == `ADCPM_OFF_STATUS) && pwdata[`ADCPM_STB_REFUSED]) begin
				refused <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Serial frame engine
	// ****************************************************************
	adcpm_shifter u_shifter (
		.pclk     (pclk),
		.presetn  (presetn),
		.start    (sh_start),
		.tx_word  (sh_tx),
		.dout_pin (adc_dout),
		.cs_n     (adc_cs_n),
		.sclk     (adc_sclk),
		.din      (adc_din),
		.done     (sh_done),
		.rx_word  (sh_rx)
	);

	// ****************************************************************
	// Assertion helpers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hi_cnt    <= 8'h00;
			pwr_armed <= 1'b0;
		end else begin
			if (!adc_cs_n) begin
				hi_cnt <= 8'h00;
			end else if (hi_cnt != 8'hff) begin
				hi_cnt <= hi_cnt + 8'h01;
			end
			if ((state == ST_FRAME) && sh_done && need_pwr) begin
				pwr_armed <= 1'b1;
			end else if (!adc_cs_n) begin
				pwr_armed <= 1'b0;
			end
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	quiet_gap_a: assert property ($fell(adc_cs_n) |-> hi_cnt >= QUIET_CYC)
		else $error("chip select fell before the quiet time");
	powerup_gap_a: assert property (($fell(adc_cs_n) && pwr_armed) |-> hi_cnt >= POWERUP_CYC)
		else $error("chip select fell before the power-up time");
	pm_forced_a: assert property ((sh_start && (cur_kind inside {K_CFG, K_DUMMY, K_CONV})) |->
		sh_tx[`ADCPM_BIT_PM_HI:`ADCPM_BIT_PM_LO] == mode_reg)
		else $error("power bits in frame differ from the chosen mode");
	dummy_nowrite_a: assert property ((sh_start && (cur_kind == K_DUMMY)) |-> !sh_tx[`ADCPM_BIT_WRITE])
		else $error("wake-up dummy frame carries a write");
	ones_frame_a: assert property ((sh_start && (cur_kind == K_ONES)) |-> sh_tx == `ADCPM_ONES_WORD)
		else $error("initialisation frame is not all ones");
	auto_dummy_a: assert property ((sh_start && (cur_kind == K_CONV) && cur_auto) |->
		(prev_kind == K_DUMMY) && (wake_cnt == 8'h00))
		else $error("auto conversion without dummy and wake time");
	shadow_init_a: assert property ((sh_start && (cur_kind == K_SHADOW)) |-> init_done && shadow_armed)
		else $error("sequence register written before initialisation");
	init_order_a: assert property ((sh_start && (cur_kind == K_CFG) && (job == JOB_INIT)) |->
		step == (skip2 ? 2'h1 : 2'h2))
		else $error("initialisation configuration frame out of place");
	idle_high_a: assert property ((state == ST_IDLE) |-> adc_cs_n)
		else $error("chip select low while idle");
	apb_ready_a: assert property ((psel && !penable) |=> pready ##1 !pready)
		else $error("bus answer not given in the access cycle");

	init_done_c: cover property ((state == ST_FRAME) && sh_done && (job == JOB_INIT) && (cur_kind == K_CFG));
	conv_done_c: cover property ((state == ST_FRAME) && sh_done && (cur_kind == K_CONV) && cur_auto);
	shadow_c: cover property (sh_start && (cur_kind == K_SHADOW));
	wake_full_c: cover property ($fell(adc_cs_n) && pwr_armed);
endmodule

// File: testbench/adcpm_dev_model.sv
// Behavioural converter that answers the host controller's serial frames.
`timescale 1ns/1ps
`include "adcpm_regs.svh"

module adcpm_dev_model #(
	parameter logic [11:0] CODE_FULL = 12'h09c3,
	parameter logic [11:0] CODE_HALF = 12'h04e1
) (
	input  logic cs_n,
	input  logic sclk,
	input  logic din,
	output logic dout
);
	logic [15:0] ctrl = 16'hxxxx;
	logic [1:0]  pm = 2'bxx;
	logic [15:0] shadow, rx, tx;
	logic        armed = 0, asleep = 0, rel = 1, last = 0, track = 1;
	int          falls = 0, frames = 0;
	realtime     ready_t = 0.0;
	// A released output shows the inverse of its last bit.
	assign dout = (cs_n || rel) ? ~last : tx[15];
	always @(negedge cs_n) begin
		track = 0;
		if (pm === `ADCPM_PM_AUTO && asleep) begin
			asleep = 0;
			ready_t = $realtime + `ADCPM_WAKE_NS;
		end
		tx = {1'b0, ctrl[`ADCPM_BIT_ADDR_HI:`ADCPM_BIT_ADDR_LO], 12'h000};
		if ((pm === `ADCPM_PM_NORMAL || pm === `ADCPM_PM_AUTO) && $realtime >= ready_t) begin
			tx[11:0] = ctrl[`ADCPM_BIT_RANGE] ? CODE_FULL : CODE_HALF;
		end
		rel = 0;
		falls = 0;
		last = 0;
	end
	always @(negedge sclk) begin
		if (!cs_n) begin
			rx = {rx[14:0], din};
			falls++;
			if (falls == 14 && pm === `ADCPM_PM_NORMAL) track = 1;
			last = tx[15];
			tx = tx << 1;
			rel = (falls >= 16);
		end
	end
	always @(posedge cs_n) begin
		rel = 1;
		frames++;
		if (falls >= 16) begin
			if (armed) begin
				shadow = rx;
				armed = 0;
			end else if (rx[`ADCPM_BIT_WRITE]) begin
				ctrl = {rx[15:4], ctrl[3:0]};
				if (rx[9:8] == `ADCPM_PM_NORMAL && pm !== `ADCPM_PM_NORMAL) begin
					ready_t = $realtime + `ADCPM_POWERUP_NS;
				end
				pm = rx[9:8];
				asleep = (pm == `ADCPM_PM_AUTO);
				armed = !rx[`ADCPM_BIT_SEQ] && rx[`ADCPM_BIT_SHADOW];
			end
		end
	end
endmodule

// File: testbench/adcpm_host_tb.sv
// Self-checking bench for the converter host controller.
`timescale 1ns/1ps
`include "adcpm_regs.svh"

module adcpm_host_tb;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic        pready, pslverr, err, cs_n, sclk, din, dout;
	int          error_cnt = 0, n_tests = 0, f0;
	always #20 pclk = ~pclk;
	adcpm_host u_adcpm_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .adc_cs_n(cs_n), .adc_sclk(sclk), .adc_din(din), .adc_dout(dout));
	adcpm_dev_model u_adcpm_dev_model (.cs_n(cs_n), .sclk(sclk), .din(din), .dout(dout));
	task automatic wrap_up;
		$display("Comparisons %0d, errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 16);
		if (i >= 16) begin
			error_cnt++;
			wrap_up();
		end
		rd = prdata;
		err = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge pclk);
	endtask
	task automatic cmd(input logic [31:0] c);
		int i;
		apb(1, `ADCPM_OFF_CMD, c);
		for (i = 0; i < 40 && cs_n !== 1'b0; i++) @(posedge pclk);
		i = 0;
		do begin
			apb(0, `ADCPM_OFF_STATUS, 32'h0000_0000);
			i++;
		end while (rd[0] !== 1'b0 && i < 400);
		if (i >= 400) begin
			error_cnt++;
			wrap_up();
		end
	endtask
	task automatic conv(input logic [1:0] m, input logic [15:0] c, input int nf, input logic [11:0] code);
		apb(1, `ADCPM_OFF_MODE, {30'h0, m});
		apb(1, `ADCPM_OFF_CTRL, {16'h0, c});
		cmd(32'h1 << `ADCPM_CMD_CFG);
		f0 = u_adcpm_dev_model.frames;
		cmd(32'h1 << `ADCPM_CMD_CONV);
		chk("frames", u_adcpm_dev_model.frames - f0, nf);
		apb(0, `ADCPM_OFF_RESULT, 32'h0000_0000);
		chk("result", rd, {16'h0, 1'b0, c[12:10], code});
		apb(0, `ADCPM_OFF_STATUS, 32'h0000_0000);
		chk("mode", {30'h0, rd[6:5]}, {30'h0, m});
	endtask
	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1;
		@(posedge pclk);
		apb(0, `ADCPM_OFF_MODE, 32'h0000_0000);
		chk("mode_rst", rd, 32'h0000_0003);
		apb(0, 8'h20, 32'h0000_0000);
		chk("unmapped", {rd[30:0], err}, 32'h0000_0001);
		cmd(32'h1 << `ADCPM_CMD_CONV);
		apb(0, `ADCPM_OFF_STATUS, 32'h0000_0000);
		chk("refused", rd & 32'h0000_000f, 32'h0000_0008);
		f0 = u_adcpm_dev_model.frames;
		cmd(32'h1 << `ADCPM_CMD_INIT);
		chk("init_frames", u_adcpm_dev_model.frames - f0, 2);
		chk("init_pm", {30'h0, u_adcpm_dev_model.pm}, 32'h0000_0003);
		conv(2'b11, 16'h1420, 1, 12'h9c3);
		chk("track", {31'h0, u_adcpm_dev_model.track}, 32'h0000_0001);
		conv(2'b11, 16'h0800, 1, 12'h4e1);
		conv(2'b10, 16'h1420, 1, 12'h000);
		conv(2'b11, 16'h1420, 1, 12'h9c3);
		conv(2'b01, 16'h0c20, 2, 12'h9c3);
		conv(2'b01, 16'h0c20, 2, 12'h9c3);
		apb(1, `ADCPM_OFF_CTRL, 32'h0000_0080);
		cmd(32'h1 << `ADCPM_CMD_CFG);
		apb(0, `ADCPM_OFF_STATUS, 32'h0000_0000);
		chk("armed", rd & 32'h0000_0010, 32'h0000_0010);
		apb(1, `ADCPM_OFF_SHADOW, 32'h0000_a5c3);
		cmd(32'h1 << `ADCPM_CMD_SHADOW);
		chk("shadow", {16'h0, u_adcpm_dev_model.shadow}, 32'h0000_a5c3);
		wrap_up();
	end
endmodule
